/* rtl/usart_consts.svh */
// Register map, field positions, reset values and timing counts of the serial enable block
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// ***********************************
// Register byte offsets
// ***********************************
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_SYNC_BUSY 8'h1c

// ***********************************
// Control one fields
// ***********************************
`define C1_ENABLE 1
`define C1_CLK_MASTER 2
`define C1_TX_SEL_LO 16
`define C1_RX_SEL_LO 20

// ***********************************
// Control two fields
// ***********************************
`define C2_RESET 32'h0000_0000
`define C2_RECEIVER_ON 17
`define C2_TRANSMITTER_ON 16
`define C2_PARITY_MODE 13
`define C2_IRDA_ENCODING 10
`define C2_START_FRAME_DETECT 9
`define C2_COLLISION_DETECT_ON 8
`define C2_STOP_BIT_COUNT 6
`define C2_CHAR_SIZE_LO 0

// ***********************************
// Status, interrupt and sync busy fields
// ***********************************
`define ST_FRAME_ERROR 0
`define ST_PARITY_ERROR 1
`define ST_BUFFER_OVERFLOW 2
`define IRQ_TX_DRAINED 3
`define IRQ_SYNC_DONE 4
`define SB_ENABLE 1
`define SB_CONTROL_TWO 2

// ***********************************
// Timing
// ***********************************
`define SYNC_TIME_NS 16
`define CLK_PERIOD_NS 4
`define SYNC_CYCLES 3'((`SYNC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/usart_pkg.sv */
// Types shared by the serial enable block
package usart_pkg;

  typedef struct packed {
    logic busy;
    logic done;
    logic [2:0] count;
  } sync_stage_s;

  typedef struct packed {
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    logic [3:0] pad_pull;
    logic [3:0] pad_drive;
    logic rxd;
    logic serial_clock_pin;
  } pad_mux_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mod_req;
    logic core_en;
    logic clk_master;
    logic [1:0] tx_sel;
    logic [1:0] rx_sel;
    logic parity_mode;
    logic irda_encoding;
    logic start_frame_detect;
    logic collision_detect_on;
    logic stop_bit_count;
    logic [2:0] character_size;
    logic receiver_on;
    logic transmitter_on;
    logic rx_pend;
    logic tx_pend;
    logic tx_off_pend;
    logic [2:0] err;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic irq;
    logic rx_flush;
    logic rx_active;
    logic tx_active;
  } enable_ctrl_s;

endpackage

/* rtl/usart_sync_stage.sv */
// Fixed-latency handover of a register write into the core clock domain
`include "usart_consts.svh"

module usart_sync_stage
  import usart_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic start,
  output logic busy,
  output logic done
);

  sync_stage_s st_reg;
  sync_stage_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.busy) begin
      if (st_reg.count == 3'h1) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.count = 3'h0;
      end else begin
        st_next.count = st_reg.count - 3'h1;
      end
    end else if (start) begin
      st_next.busy = 1'b1;
      st_next.count = `SYNC_CYCLES;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule

/* rtl/usart_pad_mux.sv */
// Routing of transmit, receive and serial clock signals onto the four pads
`include "usart_consts.svh"

module usart_pad_mux
  import usart_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic core_en,
  input wire logic tx_on,
  input wire logic rx_on,
  input wire logic clk_master,
  input wire logic [1:0] tx_sel,
  input wire logic [1:0] rx_sel,
  input wire logic txd_bit,
  input wire logic xck_bit,
  input wire logic [3:0] pull_in,
  input wire logic [3:0] drive_in,
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  output logic [3:0] pad_pull,
  output logic [3:0] pad_drive,
  output logic rxd,
  output logic serial_clock_pin
);

  pad_mux_s st_reg;
  pad_mux_s st_next;

  // Pad of the serial clock: the one after the transmit pad
  function automatic logic [1:0] clock_pad(input logic [1:0] sel);
    clock_pad = (sel == 2'h1) ? 2'h3 : 2'h1;
  endfunction

  // Pad of transmit data
  function automatic logic [1:0] data_pad(input logic [1:0] sel);
    data_pad = (sel == 2'h1) ? 2'h2 : 2'h0;
  endfunction

  always_comb begin
    logic tx_use;
    logic xck_use;
    tx_use = 1'b0;
    xck_use = 1'b0;
    st_next = st_reg;
    st_next.pad_out = 4'h0;
    st_next.pad_oe = 4'h0;
    tx_use = core_en & tx_on;
    xck_use = core_en & (tx_on | rx_on) & clk_master & (tx_sel != 2'h2);
    if (tx_use) begin
      st_next.pad_out[data_pad(tx_sel)] = txd_bit;
      st_next.pad_oe[data_pad(tx_sel)] = 1'b1;
    end
    if (xck_use) begin
      st_next.pad_out[clock_pad(tx_sel)] = xck_bit;
      st_next.pad_oe[clock_pad(tx_sel)] = 1'b1;
    end
    st_next.rxd = (core_en & rx_on) ? pad_in[rx_sel] : 1'b1;
    st_next.serial_clock_pin = pad_in[clock_pad(tx_sel)];
    st_next.pad_pull = pull_in;
    st_next.pad_drive = drive_in;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '{pad_out: 4'h0, pad_oe: 4'h0, pad_pull: 4'h0, pad_drive: 4'h0, rxd: 1'b1, serial_clock_pin: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pad_out = st_reg.pad_out;
  assign pad_oe = st_reg.pad_oe;
  assign pad_pull = st_reg.pad_pull;
  assign pad_drive = st_reg.pad_drive;
  assign rxd = st_reg.rxd;
  assign serial_clock_pin = st_reg.serial_clock_pin;

endmodule

/* rtl/usart_enable_ctrl.sv */
// Receiver and transmitter enable control with APB registers and pad ownership
//
// Decided for this implementation: the APB register port.
`include "usart_consts.svh"

module usart_enable_ctrl
  import usart_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WRITE_LOCK,
  input wire logic TX_BUSY,
  input wire logic TX_DATA_BIT,
  input wire logic XCK_DRIVE_BIT,
  input wire logic RX_FRAME_ERROR,
  input wire logic RX_PARITY_ERROR,
  input wire logic RX_OVERFLOW,
  input wire logic [3:0] PIN_PULL_ENABLE,
  input wire logic [3:0] PIN_DRIVE_STRENGTH,
  input wire logic [3:0] PAD_IN,
  output logic [3:0] PAD_OUT,
  output logic [3:0] PAD_OE,
  output logic [3:0] PAD_PULL,
  output logic [3:0] PAD_DRIVE,
  output logic RX_DATA_BIT,
  output logic XCK_SAMPLE_BIT,
  output logic RX_FLUSH,
  output logic RECEIVER_ACTIVE,
  output logic TRANSMITTER_ACTIVE,
  output logic CORE_ENABLED,
  output logic IRQ
);

  // ***********************************
  // State
  // ***********************************
  enable_ctrl_s st_reg;
  enable_ctrl_s st_next;
  logic c2_sync_start;
  logic c2_sync_busy;
  logic c2_sync_done;
  logic en_sync_start;
  logic en_sync_busy;
  logic en_sync_done;

  // ***********************************
  // Bus decode
  // ***********************************
  logic setup;
  logic access;
  logic wr;
  logic rd;
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & st_reg.pready;
  assign wr = access & PWRITE;
  assign rd = access & ~PWRITE;

  function automatic logic known_offset(input logic [7:0] a);
    known_offset = (a == `OFS_CONTROL_ONE) | (a == `OFS_CONTROL_TWO) | (a == `OFS_STATUS) |
                   (a == `OFS_IRQ_MASK) | (a == `OFS_IRQ_STATUS) | (a == `OFS_SYNC_BUSY);
  endfunction

  // Writes that the access lock refuses
  function automatic logic locked_offset(input logic [7:0] a);
    locked_offset = (a == `OFS_CONTROL_ONE) | (a == `OFS_CONTROL_TWO) | (a == `OFS_IRQ_MASK);
  endfunction

  function automatic logic [31:0] control_two_word(input enable_ctrl_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`C2_RECEIVER_ON] = s.receiver_on;
    w[`C2_TRANSMITTER_ON] = s.transmitter_on;
    w[`C2_PARITY_MODE] = s.parity_mode;
    w[`C2_IRDA_ENCODING] = s.irda_encoding;
    w[`C2_START_FRAME_DETECT] = s.start_frame_detect;
    w[`C2_COLLISION_DETECT_ON] = s.collision_detect_on;
    w[`C2_STOP_BIT_COUNT] = s.stop_bit_count;
    w[`C2_CHAR_SIZE_LO +: 3] = s.character_size;
    control_two_word = w;
  endfunction

  // ***********************************
  // Next state
  // ***********************************
  always_comb begin
    logic wr_ok;
    logic c2_wr;
    logic c1_wr;
    logic new_rx;
    logic new_tx;
    logic [4:0] irq_set;
    logic [31:0] rdata;
    logic en_hold;
    logic c2_hold;
    wr_ok = 1'b0;
    c2_wr = 1'b0;
    c1_wr = 1'b0;
    new_rx = 1'b0;
    new_tx = 1'b0;
    irq_set = 5'h00;
    rdata = 32'h0000_0000;
    // Busy until the synchronised value has landed
    en_hold = en_sync_busy | en_sync_done;
    c2_hold = c2_sync_busy | c2_sync_done;
    st_next = st_reg;
    st_next.rx_flush = 1'b0;
    c2_sync_start = 1'b0;
    en_sync_start = 1'b0;

    // Bus answer one cycle after setup
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (setup) begin
      case (PADDR)
        `OFS_CONTROL_ONE: begin
          rdata[`C1_ENABLE] = st_reg.mod_req;
          rdata[`C1_CLK_MASTER] = st_reg.clk_master;
          rdata[`C1_TX_SEL_LO +: 2] = st_reg.tx_sel;
          rdata[`C1_RX_SEL_LO +: 2] = st_reg.rx_sel;
        end
        `OFS_CONTROL_TWO: rdata = control_two_word(st_reg);
        `OFS_STATUS: rdata[2:0] = st_reg.err;
        `OFS_IRQ_MASK: rdata[4:0] = st_reg.irq_mask;
        `OFS_IRQ_STATUS: rdata[4:0] = st_reg.irq_stat;
        `OFS_SYNC_BUSY: begin
          rdata[`SB_ENABLE] = en_hold;
          rdata[`SB_CONTROL_TWO] = c2_hold;
        end
        default: rdata = 32'h0000_0000;
      endcase
      st_next.prdata = PWRITE ? 32'h0000_0000 : rdata;
      st_next.pslverr = ~known_offset(PADDR) | (PWRITE & WRITE_LOCK & locked_offset(PADDR));
    end

    wr_ok = wr & ~st_reg.pslverr;
    c1_wr = wr_ok & (PADDR == `OFS_CONTROL_ONE) & ~en_hold;
    c2_wr = wr_ok & (PADDR == `OFS_CONTROL_TWO) & ~c2_hold;

    // Control one: module enable runs through the synchroniser
    if (c1_wr) begin
      st_next.mod_req = PWDATA[`C1_ENABLE];
      en_sync_start = PWDATA[`C1_ENABLE] != st_reg.core_en;
      if (!st_reg.core_en) begin
        st_next.clk_master = PWDATA[`C1_CLK_MASTER];
        st_next.tx_sel = PWDATA[`C1_TX_SEL_LO +: 2];
        st_next.rx_sel = PWDATA[`C1_RX_SEL_LO +: 2];
      end
    end
    if (en_sync_done) begin
      st_next.core_en = st_reg.mod_req;
    end

    // Control two
    if (c2_wr) begin
      new_rx = PWDATA[`C2_RECEIVER_ON];
      new_tx = PWDATA[`C2_TRANSMITTER_ON];
      if (!st_reg.core_en) begin
        st_next.parity_mode = PWDATA[`C2_PARITY_MODE];
        st_next.irda_encoding = PWDATA[`C2_IRDA_ENCODING];
        st_next.start_frame_detect = PWDATA[`C2_START_FRAME_DETECT];
        st_next.collision_detect_on = PWDATA[`C2_COLLISION_DETECT_ON];
        st_next.stop_bit_count = PWDATA[`C2_STOP_BIT_COUNT];
        st_next.character_size = PWDATA[`C2_CHAR_SIZE_LO +: 3];
      end
      if (!new_rx) begin
        st_next.receiver_on = 1'b0;
        st_next.rx_pend = 1'b0;
        st_next.rx_flush = 1'b1;
        st_next.err = 3'h0;
      end else if (!st_reg.receiver_on) begin
        if (!st_reg.core_en) begin
          st_next.receiver_on = 1'b1;
        end else begin
          st_next.rx_pend = 1'b1;
          c2_sync_start = 1'b1;
        end
      end
      if (!new_tx) begin
        st_next.tx_pend = 1'b0;
        st_next.tx_off_pend = st_reg.transmitter_on;
      end else begin
        st_next.tx_off_pend = 1'b0;
        if (!st_reg.transmitter_on) begin
          if (!st_reg.core_en) begin
            st_next.transmitter_on = 1'b1;
          end else begin
            st_next.tx_pend = 1'b1;
            c2_sync_start = 1'b1;
          end
        end
      end
    end

    // Requests finish when the core has taken them
    if (c2_sync_done) begin
      if (st_reg.rx_pend) begin
        st_next.receiver_on = 1'b1;
      end
      if (st_reg.tx_pend) begin
        st_next.transmitter_on = 1'b1;
      end
      st_next.rx_pend = 1'b0;
      st_next.tx_pend = 1'b0;
      irq_set[`IRQ_SYNC_DONE] = 1'b1;
    end

    // Transmitter stays on until the last frame has left
    if (st_reg.tx_off_pend && !TX_BUSY && !c2_wr) begin
      st_next.transmitter_on = 1'b0;
      st_next.tx_off_pend = 1'b0;
      irq_set[`IRQ_TX_DRAINED] = 1'b1;
    end

    // Clear first, so an error in the same cycle survives
    if (wr_ok && PADDR == `OFS_STATUS) begin
      st_next.err = st_next.err & ~PWDATA[2:0];
    end
    // Receive errors are kept only while the receiver is on
    if (st_reg.receiver_on && !(c2_wr && !new_rx)) begin
      st_next.err[`ST_FRAME_ERROR] = st_next.err[`ST_FRAME_ERROR] | RX_FRAME_ERROR;
      st_next.err[`ST_PARITY_ERROR] = st_next.err[`ST_PARITY_ERROR] | RX_PARITY_ERROR;
      st_next.err[`ST_BUFFER_OVERFLOW] = st_next.err[`ST_BUFFER_OVERFLOW] | RX_OVERFLOW;
      irq_set[2:0] = {RX_OVERFLOW, RX_PARITY_ERROR, RX_FRAME_ERROR};
    end

    // ***********************************
    // Interrupts
    // ***********************************
    if (wr_ok && PADDR == `OFS_IRQ_MASK) begin
      st_next.irq_mask = PWDATA[4:0];
    end
    // Read clears only what it reported
    if (rd && PADDR == `OFS_IRQ_STATUS) begin
      st_next.irq_stat = (st_reg.irq_stat & ~st_reg.prdata[4:0]) | irq_set;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | irq_set;
    end
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
    st_next.rx_active = st_next.receiver_on & st_next.core_en;
    st_next.tx_active = st_next.transmitter_on & st_next.core_en;
  end

  // ***********************************
  // Registers
  // ***********************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ***********************************
  // Synchronisers and pads
  // ***********************************
  usart_sync_stage u_c2_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .start(c2_sync_start),
    .busy(c2_sync_busy),
    .done(c2_sync_done)
  );

  usart_sync_stage u_en_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .start(en_sync_start),
    .busy(en_sync_busy),
    .done(en_sync_done)
  );

  usart_pad_mux u_pads (
    .CLK(CLK),
    .RST_B(RST_B),
    .core_en(st_reg.core_en),
    .tx_on(st_reg.transmitter_on),
    .rx_on(st_reg.receiver_on),
    .clk_master(st_reg.clk_master),
    .tx_sel(st_reg.tx_sel),
    .rx_sel(st_reg.rx_sel),
    .txd_bit(TX_DATA_BIT),
    .xck_bit(XCK_DRIVE_BIT),
    .pull_in(PIN_PULL_ENABLE),
    .drive_in(PIN_DRIVE_STRENGTH),
    .pad_in(PAD_IN),
    .pad_out(PAD_OUT),
    .pad_oe(PAD_OE),
    .pad_pull(PAD_PULL),
    .pad_drive(PAD_DRIVE),
    .rxd(RX_DATA_BIT),
    .serial_clock_pin(XCK_SAMPLE_BIT)
  );

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign RX_FLUSH = st_reg.rx_flush;
  assign RECEIVER_ACTIVE = st_reg.rx_active;
  assign TRANSMITTER_ACTIVE = st_reg.tx_active;
  assign CORE_ENABLED = st_reg.core_en;
  assign IRQ = st_reg.irq;

endmodule

/* sim/usart_enable_ctrl_sva.sv */
// Checker for APB timing, pad ownership and enable state of the serial block
`include "usart_consts.svh"
module usart_enable_ctrl_sva
  import usart_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TX_BUSY,
  input wire logic [3:0] PIN_PULL_ENABLE,
  input wire logic [3:0] PIN_DRIVE_STRENGTH,
  input wire logic [3:0] PAD_OE,
  input wire logic [3:0] PAD_PULL,
  input wire logic [3:0] PAD_DRIVE,
  input wire logic RX_DATA_BIT,
  input wire logic RX_FLUSH,
  input wire logic RECEIVER_ACTIVE,
  input wire logic TRANSMITTER_ACTIVE,
  input wire logic CORE_ENABLED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence rx_on_req_s;
    PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == `OFS_CONTROL_TWO &&
      PWDATA[`C2_RECEIVER_ON] && CORE_ENABLED && !RECEIVER_ACTIVE;
  endsequence
  sequence tx_on_req_s;
    PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == `OFS_CONTROL_TWO &&
      PWDATA[`C2_TRANSMITTER_ON] && CORE_ENABLED && !TRANSMITTER_ACTIVE;
  endsequence
  wire logic idle_both = !RECEIVER_ACTIVE && !TRANSMITTER_ACTIVE;
  a_apb_one_access: assert property (setup_s |=> access_s ##1 !PREADY)
    else $error("access phase not one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_pad_attr_pass: assert property ($past(RST_B) |->
    PAD_PULL == $past(PIN_PULL_ENABLE) && PAD_DRIVE == $past(PIN_DRIVE_STRENGTH))
    else $error("pad pull or drive not passed");
  a_flush_rx_off: assert property (RX_FLUSH |-> !RECEIVER_ACTIVE)
    else $error("flush while receiver active");
  a_flush_one_pulse: assert property (RX_FLUSH |=> !RX_FLUSH)
    else $error("flush longer than one cycle");
  a_pads_released: assert property (idle_both && $past(idle_both) |-> PAD_OE == 4'h0)
    else $error("pad driven while both off");
  a_rxd_idle_high: assert property (!RECEIVER_ACTIVE && $past(!RECEIVER_ACTIVE) |-> RX_DATA_BIT)
    else $error("receive sample not idle");
  a_tx_drain_hold: assert property ($past(TRANSMITTER_ACTIVE && TX_BUSY) && CORE_ENABLED |-> TRANSMITTER_ACTIVE)
    else $error("transmitter stopped while busy");
  a_rx_sync_delay: assert property (rx_on_req_s |=> !RECEIVER_ACTIVE [*5] ##1 RECEIVER_ACTIVE)
    else $error("receiver on without sync delay");
  a_tx_sync_delay: assert property (tx_on_req_s |=> !TRANSMITTER_ACTIVE [*5] ##1 TRANSMITTER_ACTIVE)
    else $error("transmitter on without sync delay");
endmodule

/* sim/usart_line_partner.sv */
// Far-end serial line model that drives the pad inputs
module usart_line_partner (
  input wire logic clk,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [1:0] rx_pad,
  input wire logic line_bit,
  output logic [3:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic churn_reg = 1'b0;
  always @(posedge clk) begin
    churn_reg <= ~churn_reg;
  end
  // Undriven pads other than the receive pad toggle so a stale level never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (i == int'(rx_pad)) pad_in[i] = line_bit;
      else pad_in[i] = churn_reg ^ i[0];
    end
  end
endmodule

/* sim/usart_enable_ctrl_tb_top.sv */
// Self-checking bench for the serial enable control block
`include "usart_consts.svh"
module usart_enable_ctrl_tb_top
  import usart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FMT = 32'h0000_2747;
  localparam logic [31:0] RXB = 32'h0002_0000;
  localparam logic [31:0] TXB = 32'h0001_0000;
  logic CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, WRITE_LOCK = 1'b0, TX_BUSY = 1'b0, TX_DATA_BIT = 1'b0, XCK_DRIVE_BIT = 1'b0;
  logic RX_FRAME_ERROR = 1'b0, RX_PARITY_ERROR = 1'b0, RX_OVERFLOW = 1'b0, far_bit = 1'b1;
  logic [3:0] PIN_PULL_ENABLE = 4'h0, PIN_DRIVE_STRENGTH = 4'h0, PAD_IN, PAD_OUT, PAD_OE, PAD_PULL, PAD_DRIVE;
  logic RX_DATA_BIT, XCK_SAMPLE_BIT, RX_FLUSH, RECEIVER_ACTIVE, TRANSMITTER_ACTIVE, CORE_ENABLED, IRQ;
  logic er, flush_seen = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  always #2 CLK = ~CLK;
  always @(posedge CLK) if (RX_FLUSH === 1'b1) flush_seen <= 1'b1;
  usart_enable_ctrl dut_u (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .WRITE_LOCK, .TX_BUSY, .TX_DATA_BIT, .XCK_DRIVE_BIT, .RX_FRAME_ERROR, .RX_PARITY_ERROR,
    .RX_OVERFLOW, .PIN_PULL_ENABLE, .PIN_DRIVE_STRENGTH, .PAD_IN, .PAD_OUT, .PAD_OE, .PAD_PULL,
    .PAD_DRIVE, .RX_DATA_BIT, .XCK_SAMPLE_BIT, .RX_FLUSH, .RECEIVER_ACTIVE, .TRANSMITTER_ACTIVE,
    .CORE_ENABLED, .IRQ);
  usart_line_partner far_u (.clk(CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE), .rx_pad(2'd1),
    .line_bit(far_bit), .pad_in(PAD_IN));
  // ***********************************
  // Shared tasks
  // ***********************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task wait_sync;
    do apb(1'b0, `OFS_SYNC_BUSY, 32'h0); while (rd !== 32'h0);
  endtask
  task complete_run;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ***********************************
  // Scenarios
  // ***********************************
  task t_reset;
    rd_chk(`OFS_CONTROL_TWO, `C2_RESET);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, `OFS_CONTROL_TWO, FMT);
    rd_chk(`OFS_CONTROL_TWO, FMT);
    WRITE_LOCK <= 1'b1;
    apb(1'b1, `OFS_CONTROL_TWO, 32'h0);
    chk(32'(er), 32'h1);
    WRITE_LOCK <= 1'b0;
    rd_chk(`OFS_CONTROL_TWO, FMT);
    $display("test reset_format done");
  endtask
  task t_arm;
    apb(1'b1, `OFS_CONTROL_TWO, FMT | RXB | TXB);
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB | TXB);
    chk(32'({CORE_ENABLED, RECEIVER_ACTIVE, TRANSMITTER_ACTIVE}), 32'h0);
    PIN_PULL_ENABLE <= 4'ha;
    PIN_DRIVE_STRENGTH <= 4'h5;
    TX_DATA_BIT <= 1'b1;
    XCK_DRIVE_BIT <= 1'b1;
    far_bit <= 1'b0;
    apb(1'b1, `OFS_CONTROL_ONE, 32'h0011_0006);
    wait_sync;
    chk(32'({CORE_ENABLED, RECEIVER_ACTIVE, TRANSMITTER_ACTIVE}), 32'h7);
    chk(32'(PAD_OE), 32'hc);
    chk(32'(PAD_OUT[3:2]), 32'h3);
    chk(32'(XCK_SAMPLE_BIT), 32'h1);
    chk(32'({PAD_PULL, PAD_DRIVE}), 32'ha5);
    chk(32'(RX_DATA_BIT), 32'h0);
    far_bit <= 1'b1;
    repeat (3) @(posedge CLK);
    chk(32'(RX_DATA_BIT), 32'h1);
    $display("test arm_and_pads done");
  endtask
  task t_rx_off;
    RX_FRAME_ERROR <= 1'b1;
    RX_PARITY_ERROR <= 1'b1;
    RX_OVERFLOW <= 1'b1;
    @(posedge CLK);
    RX_FRAME_ERROR <= 1'b0;
    RX_PARITY_ERROR <= 1'b0;
    RX_OVERFLOW <= 1'b0;
    rd_chk(`OFS_STATUS, 32'h7);
    apb(1'b1, `OFS_CONTROL_TWO, FMT | TXB);
    rd_chk(`OFS_STATUS, 32'h0);
    chk(32'(flush_seen), 32'h1);
    rd_chk(`OFS_CONTROL_TWO, FMT | TXB);
    chk(32'(RX_DATA_BIT), 32'h1);
    $display("test receiver_off done");
  endtask
  task t_rx_on;
    apb(1'b1, `OFS_IRQ_MASK, 32'h10);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, `OFS_CONTROL_TWO, FMT | TXB | RXB);
    rd_chk(`OFS_CONTROL_TWO, FMT | TXB);
    wait_sync;
    rd_chk(`OFS_CONTROL_TWO, FMT | TXB | RXB);
    chk(32'(IRQ), 32'h1);
    rd_chk(`OFS_IRQ_STATUS, 32'h10);
    chk(32'(IRQ), 32'h0);
    $display("test receiver_on done");
  endtask
  task t_tx_drain;
    TX_BUSY <= 1'b1;
    apb(1'b1, `OFS_CONTROL_TWO, FMT | RXB);
    repeat (8) @(posedge CLK);
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB | TXB);
    chk(32'({TRANSMITTER_ACTIVE, IRQ}), 32'h2);
    TX_BUSY <= 1'b0;
    @(posedge CLK);
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB);
    rd_chk(`OFS_IRQ_STATUS, 32'h8);
    chk(32'(PAD_OE), 32'h8);
    $display("test transmit_drain done");
  endtask
  task t_tx_on;
    apb(1'b1, `OFS_CONTROL_TWO, FMT | RXB | TXB);
    rd_chk(`OFS_SYNC_BUSY, 32'h4);
    wait_sync;
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB | TXB);
    apb(1'b1, `OFS_CONTROL_TWO, RXB | TXB);
    wait_sync;
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB | TXB);
    $display("test transmit_on done");
  endtask
  task t_pinout;
    apb(1'b1, `OFS_CONTROL_ONE, 32'h0);
    wait_sync;
    chk(32'({CORE_ENABLED, PAD_OE}), 32'h0);
    rd_chk(`OFS_CONTROL_TWO, FMT | RXB | TXB);
    far_bit <= 1'b0;
    apb(1'b1, `OFS_CONTROL_ONE, 32'h0012_0006);
    wait_sync;
    chk(32'({PAD_OE, PAD_OUT[0]}), 32'h3);
    chk(32'(RX_DATA_BIT), 32'h0);
    $display("test pinout_select done");
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    t_reset;
    t_arm;
    t_rx_off;
    t_rx_on;
    t_tx_drain;
    t_tx_on;
    t_pinout;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    complete_run;
  end
endmodule
bind usart_enable_ctrl usart_enable_ctrl_sva chk_u (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .PSLVERR,
  .TX_BUSY, .PIN_PULL_ENABLE, .PIN_DRIVE_STRENGTH, .PAD_OE, .PAD_PULL, .PAD_DRIVE, .RX_DATA_BIT,
  .RX_FLUSH, .RECEIVER_ACTIVE, .TRANSMITTER_ACTIVE, .CORE_ENABLED);
